/* bic_consts.svh */
// constants for the bridge isa alias and error control block
// What this block does
// R01: isa filter blocks downstream upper-768 alias addresses
// R02: filter only in window, below 0x10000
// R03: filter passes upstream upper-768 alias addresses
// R04: filter clear forwards whole window downstream
// R05: error forward bit sends pin as message
// R06: cleared bit forwards only if mask clear
// R07: parity response set reports pci errors
// R08: parity response clear ignores pci errors
// R09: correct parity always driven on pci
// R10: data errors always forwarded as poisoned
// R11: interrupt pin field reads zero
// R12: interrupt line reads all ones, ignores writes
// R13: filter qualifies window hit, never widens
`ifndef BIC_CONSTS_SVH
`define BIC_CONSTS_SVH
`define BIC_OFF_CTRL 8'h00
`define BIC_OFF_STAT 8'h04
`define BIC_OFF_CLR 8'h08
`define BIC_OFF_EN 8'h0c
`define BIC_BIT_PARITY 16
`define BIC_BIT_ERRFWD 17
`define BIC_BIT_ISA 18
`define BIC_INT_PIN_VAL 8'h00
`define BIC_INT_LINE_VAL 8'hff
`define BIC_IO_TOP 32'h0000ffff
`define BIC_ALIAS_LOW 10'h100
`define BIC_NEV 4
`define BIC_EV_SERR 0
`define BIC_EV_ADDR 1
`define BIC_EV_ATTR 2
`define BIC_EV_DATA 3
`endif

/* bic_pkg.sv */
// types for the bridge isa alias and error control block
package bic_pkg;
  typedef logic [31:0] bic_word_t;
endpackage : bic_pkg

/* bic_bridge_ctrl.sv */
// bridge isa alias filter, error forwarding and register file
`include "bic_consts.svh"
module bic_bridge_ctrl
  import bic_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] down_io_addr,
  input wire logic down_io_valid,
  input wire logic down_window_hit,
  output logic down_io_forward,
  input wire logic [31:0] up_io_addr,
  input wire logic up_io_valid,
  input wire logic up_window_hit,
  output logic up_io_forward,
  input wire logic secondary_system_error_n,
  input wire logic aer_serr_mask,
  input wire logic err_fatal_sel,
  output logic err_msg_fatal,
  output logic err_msg_nonfatal,
  input wire logic pci_addr_err,
  input wire logic pci_attr_err,
  input wire logic pci_data_err,
  output logic pci_err_report,
  output logic pcie_poison,
  input wire logic [31:0] pci_out_data,
  output logic pci_out_parity,
  output logic irq
);
  // register file state
  bic_word_t ctrl_q;
  bic_word_t ctrl_d;
  logic [`BIC_NEV-1:0] en_q;
  logic [`BIC_NEV-1:0] en_d;
  logic [`BIC_NEV-1:0] stat_q;
  logic [`BIC_NEV-1:0] stat_d;
  logic [`BIC_NEV-1:0] ev;
  bic_word_t rdata_q;
  bic_word_t rdata_d;
  // datapath state
  logic serr_q;
  logic serr_d;
  logic fwd_q;
  logic fwd_d;
  logic rep_q;
  logic rep_d;
  logic pois_q;
  logic pois_d;
  logic dfwd_q;
  logic dfwd_d;
  logic ufwd_q;
  logic ufwd_d;
  logic par_q;
  logic par_d;
  // decoded control bits
  logic isa_on;
  logic fwd_en;
  logic par_en;
  logic serr_edge;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  logic down_alias;
  logic up_alias;

  // register write hit at one offset
  function automatic logic wr_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return wr && (addr == off);
  endfunction : wr_hit

  // address inside the low 64k of i/o space
  function automatic logic low_io(input logic [31:0] a);
    return a <= `BIC_IO_TOP;
  endfunction : low_io

  // in low 64k and upper 768 bytes of a 1k block
  function automatic logic isa_alias(input logic [31:0] a);
    return low_io(a) && (a[9:0] >= `BIC_ALIAS_LOW); // [R02]
  endfunction : isa_alias

  // downstream pass: filter qualifies only
  function automatic logic down_pass(input logic isa, input logic al);
    return !(isa && al);
  endfunction : down_pass

  // upstream pass: only alias addresses with filter on
  function automatic logic up_pass(input logic isa, input logic al);
    return isa && al;
  endfunction : up_pass

  // any uncorrectable pci side error
  function automatic logic any_err(
    input logic a,
    input logic b,
    input logic c
  );
    return a || b || c;
  endfunction : any_err

  // severity split of a forwarded error
  function automatic logic [1:0] msg_split(input logic f, input logic fat);
    return {f && fat, f && !fat};
  endfunction : msg_split

  // level interrupt from enabled status bits
  function automatic logic irq_level(
    input logic [`BIC_NEV-1:0] s,
    input logic [`BIC_NEV-1:0] e
  );
    return |(s & e);
  endfunction : irq_level

  // readback of the control word
  function automatic bic_word_t ctrl_word(input bic_word_t c);
    bic_word_t w;
    w = '0;
    w[`BIC_BIT_ISA:`BIC_BIT_PARITY] = c[`BIC_BIT_ISA:`BIC_BIT_PARITY];
    w[15:8] = `BIC_INT_PIN_VAL; // [R11]
    w[7:0] = `BIC_INT_LINE_VAL; // [R12]
    return w;
  endfunction : ctrl_word

  // readback of a status or enable field
  function automatic bic_word_t field_word(
    input logic [`BIC_NEV-1:0] f
  );
    bic_word_t w;
    w = '0;
    w[`BIC_NEV-1:0] = f;
    return w;
  endfunction : field_word

  // control bit and strobe decode
  assign isa_on = ctrl_q[`BIC_BIT_ISA];
  assign fwd_en = ctrl_q[`BIC_BIT_ERRFWD];
  assign par_en = ctrl_q[`BIC_BIT_PARITY];
  assign wr_ctrl = wr_hit(reg_wr, reg_addr, `BIC_OFF_CTRL);
  assign wr_clr = wr_hit(reg_wr, reg_addr, `BIC_OFF_CLR);
  assign wr_en = wr_hit(reg_wr, reg_addr, `BIC_OFF_EN);
  assign down_alias = isa_alias(down_io_addr);
  assign up_alias = isa_alias(up_io_addr);
  assign serr_edge = ~secondary_system_error_n & ~serr_q;

  // control register, only bits 18:16 writable
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d[`BIC_BIT_ISA:`BIC_BIT_PARITY] =
        reg_wdata[`BIC_BIT_ISA:`BIC_BIT_PARITY]; // [R11] [R12]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= '0; // [R04]
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // interrupt enable register
  always_comb begin
    en_d = en_q;
    if (wr_en) begin
      en_d = reg_wdata[`BIC_NEV-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_q <= '0;
    end else begin
      en_q <= en_d;
    end
  end

  // status events, pci errors only with parity response
  always_comb begin
    ev = '0;
    ev[`BIC_EV_SERR] = fwd_d;
    ev[`BIC_EV_ADDR] = par_en && pci_addr_err; // [R07] [R08]
    ev[`BIC_EV_ATTR] = par_en && pci_attr_err; // [R07] [R08]
    ev[`BIC_EV_DATA] = par_en && pci_data_err; // [R07] [R08]
  end

  // sticky status, set wins over clear
  always_comb begin
    stat_d = stat_q;
    if (wr_clr) begin
      stat_d = stat_q & ~reg_wdata[`BIC_NEV-1:0];
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // read data, valid only the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `BIC_OFF_CTRL: rdata_d = ctrl_word(ctrl_q); // [R11] [R12]
        `BIC_OFF_STAT: rdata_d = field_word(stat_q);
        `BIC_OFF_EN: rdata_d = field_word(en_q);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // downstream forward, window hit gates it
  always_comb begin
    dfwd_d = 1'b0;
    if (down_io_valid && down_window_hit) begin // [R13]
      dfwd_d = down_pass(isa_on, down_alias); // [R01] [R02] [R04]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dfwd_q <= 1'b0;
    end else begin
      dfwd_q <= dfwd_d;
    end
  end

  // upstream forward of alias addresses with filter on
  always_comb begin
    ufwd_d = 1'b0;
    if (up_io_valid && up_window_hit) begin // [R13]
      ufwd_d = up_pass(isa_on, up_alias); // [R03]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ufwd_q <= 1'b0;
    end else begin
      ufwd_q <= ufwd_d;
    end
  end

  // last sample of the system error pin, low is asserted
  always_comb begin
    serr_d = ~secondary_system_error_n;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serr_q <= 1'b0;
    end else begin
      serr_q <= serr_d;
    end
  end

  // one message per pin assertion
  always_comb begin
    fwd_d = 1'b0;
    if (serr_edge) begin
      fwd_d = fwd_en || !aer_serr_mask; // [R05] [R06]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fwd_q <= 1'b0;
    end else begin
      fwd_q <= fwd_d;
    end
  end

  // error report only with parity response set
  always_comb begin
    rep_d = 1'b0;
    if (par_en) begin // [R07] [R08]
      rep_d = any_err(pci_addr_err, pci_attr_err, pci_data_err);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rep_q <= 1'b0;
    end else begin
      rep_q <= rep_d;
    end
  end

  // data errors always poisoned toward pcie
  always_comb begin
    pois_d = pci_data_err; // [R10]
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pois_q <= 1'b0;
    end else begin
      pois_q <= pois_d;
    end
  end

  // parity always generated on the pci side
  always_comb begin
    par_d = ^pci_out_data; // [R09]
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      par_q <= 1'b0;
    end else begin
      par_q <= par_d;
    end
  end

  // outputs
  assign reg_rdata = rdata_q;
  assign down_io_forward = dfwd_q;
  assign up_io_forward = ufwd_q;
  assign {err_msg_fatal, err_msg_nonfatal} = msg_split(fwd_q, err_fatal_sel);
  assign pci_err_report = rep_q;
  assign pcie_poison = pois_q;
  assign pci_out_parity = par_q;
  assign irq = irq_level(stat_q, en_q);
endmodule : bic_bridge_ctrl

/* bic_partner.sv */
// secondary bus agent driving the system error pin
module bic_partner (
  input wire logic clock,
  input wire logic go,
  output logic secondary_system_error_n = 1'h1
);
  timeunit 1ns;
  timeprecision 1ns;
  // pin low while told, driven high again after
  always @(posedge clock) secondary_system_error_n <= !go;
endmodule : bic_partner

/* bic_asserts.sv */
// port assertions for the bridge control block
module bic_asserts (
  input wire logic clock, rstn, pci_data_err, pcie_poison, pci_out_parity,
  input wire logic err_msg_nonfatal, secondary_system_error_n,
  input wire logic down_io_valid, down_window_hit, down_io_forward,
  input wire logic [31:0] pci_out_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_POI: assert property (pci_data_err |=> pcie_poison)
    else $error("poison missing");
  AST_NPOI: assert property (!pci_data_err |=> !pcie_poison)
    else $error("poison spurious");
  AST_PAR: assert property (pci_out_parity == ^$past(pci_out_data))
    else $error("parity wrong");
  AST_FWD: assert property (down_io_forward |->
    $past(down_io_valid && down_window_hit)) else $error("forward no hit");
  AST_MISS: assert property (!down_window_hit |=> !down_io_forward)
    else $error("forward widened");
  AST_MSG: assert property (err_msg_nonfatal |->
    $past(!secondary_system_error_n)) else $error("message no pin");
  AST_ONE: assert property (err_msg_nonfatal |=> !err_msg_nonfatal)
    else $error("message too long");
  AST_HOLD: assert property ($past(!secondary_system_error_n, 2) &&
    $past(!secondary_system_error_n) |-> !err_msg_nonfatal)
    else $error("message repeated");
  cover property (err_msg_nonfatal);
  cover property (pcie_poison);
  cover property (down_io_forward);
endmodule : bic_asserts
bind bic_bridge_ctrl bic_asserts chk (.*);

/* tb_top.sv */
// self-checking bench for the bridge control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = '0, rstn = '0, reg_wr = '0, reg_rd = '0, go = '0;
  logic down_io_valid = '1, up_io_valid = '1, down_window_hit = '0;
  logic up_window_hit = '0, aer_serr_mask = '1, err_fatal_sel = '0;
  logic pci_addr_err = '0, pci_attr_err = '0, pci_data_err = '0;
  logic secondary_system_error_n, err_msg_fatal, err_msg_nonfatal, irq;
  logic down_io_forward, up_io_forward, pci_err_report, pcie_poison;
  logic pci_out_parity;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, down_io_addr = '0, up_io_addr = '0;
  logic [31:0] pci_out_data = '0, reg_rdata;
  int error_cnt = 0, checks_done = 0, n;
  bic_bridge_ctrl DUT (.*);
  bic_partner agent (.*);
  always #10 clock = ~clock;
  task chk(string s, logic [31:0] v, e);
    checks_done++;
    if (v !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", s, e, v);
    end
  endtask : chk
  task bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clock) {reg_wr, reg_rd} <= 2'h0;
    #1;
  endtask : bus
  task io(logic [31:0] a, logic h, logic [1:0] e, logic v = 1'h1);
    @(posedge clock) {down_io_addr, up_io_addr, pci_out_data} <= {a, a, a};
    {down_window_hit, up_window_hit} <= {h, h};
    {down_io_valid, up_io_valid} <= {v, v};
    @(posedge clock) #1;
    chk("fwd", {down_io_forward, up_io_forward}, e);
  endtask : io
  task perr(logic [2:0] v, logic e);
    @(posedge clock) {pci_addr_err, pci_attr_err, pci_data_err} <= v;
    @(posedge clock) {pci_addr_err, pci_attr_err, pci_data_err} <= 3'h0;
    #1 chk("rep", pci_err_report, e);
    chk("poison", pcie_poison, v[0]);
  endtask : perr
  task serr(logic [1:0] e);
    n = 0;
    @(posedge clock) {go, pci_data_err} <= 2'h3;
    repeat (4) @(posedge clock) #1 n += {err_msg_fatal, err_msg_nonfatal};
    @(posedge clock) {go, pci_data_err} <= 2'h0;
    repeat (2) @(posedge clock);
    chk("msg", n, e);
  endtask : serr
  task t_reg;
    bus(1'h1, 8'h00, 32'hffffffff);
    bus(1'h0, 8'h00, 32'h0);
    chk("ctrl", reg_rdata, 32'h000700ff);
    bus(1'h0, 8'h40, 32'h0);
    chk("none", reg_rdata, 32'h0);
    $display("t_reg done");
  endtask : t_reg
  task t_isa;
    io(32'h100, 1'h1, 2'h1);
    io(32'h10100, 1'h1, 2'h2);
    io(32'h100, 1'h0, 2'h0);
    bus(1'h1, 8'h00, 32'h30000);
    io(32'h500, 1'h1, 2'h2);
    io(32'h500, 1'h1, 2'h0, 1'h0);
    $display("t_isa done");
  endtask : t_isa
  task t_err;
    bus(1'h1, 8'h0c, 32'h1);
    serr(2'h1);
    chk("irq", irq, 1'h1);
    bus(1'h1, 8'h08, 32'hf);
    chk("irq", irq, 1'h0);
    bus(1'h1, 8'h00, 32'h0);
    serr(2'h0);
    aer_serr_mask <= 1'h0;
    serr(2'h1);
    err_fatal_sel <= 1'h1;
    serr(2'h2);
    $display("t_err done");
  endtask : t_err
  task t_par;
    bus(1'h1, 8'h08, 32'hf);
    bus(1'h1, 8'h00, 32'h10000);
    bus(1'h1, 8'h0c, 32'he);
    perr(3'h4, 1'h1);
    perr(3'h2, 1'h1);
    perr(3'h1, 1'h1);
    chk("irq", irq, 1'h1);
    bus(1'h0, 8'h04, 32'h0);
    chk("stat", reg_rdata, 32'he);
    bus(1'h0, 8'h0c, 32'h0);
    chk("en", reg_rdata, 32'he);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h08, 32'hf);
    perr(3'h7, 1'h0);
    bus(1'h0, 8'h04, 32'h0);
    chk("stat", reg_rdata, 32'h0);
    $display("t_par done");
  endtask : t_par
  task final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (1000) @(posedge clock);
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    t_reg;
    t_isa;
    t_err;
    t_par;
    final_report;
  end
endmodule : tb_top
